// *** verilog/mtc_timer_core.v ***
// Six-channel timer core with an AXI4-Lite register slave.
// What this block does
// - six sixteen-bit readable writable counters
// - counters zero on reset and standby
// - compare registers sixteen bits, read/write
// - sixteen compare registers: four, two, two
// - channels 0,3: C buffers A, D buffers B
// - run bits start/stop counters, reset zero
// - stopping holds the pin output level
// - pin control write while stopped sets level
// - lockstep bits choose independent or synchronous
// - synchronous preset and clear across channels
// - counters count upward only
// - setting run bit starts counting
// - overflow sets flag, counting continues from zero
// - period match sets flag, clears counter
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.vh"
module mtc_timer_core (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst,
  // AXI4-Lite write address.
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address.
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Count clock enable pulse, same clock domain.
  input  wire        countTick,
  // Compare output levels of the timer_io_pin outputs.
  output reg  [5:0]  timerIoPin
);
  // Run bits and lockstep bits.
  reg  [5:0]  runBit_reg;
  reg  [5:0]  lockstepBit_reg;
  // Hardware standby holds the counters at zero.
  reg         standby_reg;
  // Per-channel control: clear source, buffer enables.
  reg  [4:0]  chCtrl_reg [0:5];
  // Per-channel pin initial level: bit1 valid, bit0 level.
  reg  [1:0]  pinCtl_reg [0:5];
  // Sticky flags: bit4 overflow, bits 3..0 match D..A.
  reg  [4:0]  flag_reg [0:5];
  // Latched write address and data, with their hold flags.
  reg  [11:0] wAddr_reg;
  reg         wAddrHeld_reg;
  reg  [31:0] wData_reg;
  reg  [3:0]  wStrb_reg;
  reg         wDataHeld_reg;
  // Per-channel signals from the channel modules.
  wire [15:0] cnt    [0:5];
  wire [63:0] grs    [0:5];
  wire [5:0]  ovf;
  wire [3:0]  mev    [0:5];
  wire [5:0]  clr;
  wire [5:0]  pin;
  // Decoded write strobe, the aligned address and the channel index.
  wire        doWrite;
  wire [11:0] chRel;
  wire [2:0]  wCh;
  wire [5:0]  wReg;
  wire        wFull;
  wire        wInCh;
  // Synchronous events among lockstep channels.
  wire        syncClear;
  reg  [31:0] rdValue;
  reg         rdErr;
  reg         wrErr;

  assign doWrite = wAddrHeld_reg && wDataHeld_reg && !s_axi_bvalid;
  assign chRel   = wAddr_reg - `MTC_OFF_CH_BASE;
  assign wCh     = chRel[8:6];
  assign wReg    = chRel[5:0];
  // Upper offset bits must be clear, or high addresses would alias a channel.
  assign wInCh   = wAddr_reg >= `MTC_OFF_CH_BASE && chRel[11:9] == 3'd0 &&
                   wCh < 3'd6;
  // Counters and compare registers take only whole half-words.
  assign wFull   = wStrb_reg[1:0] == 2'b11;
  assign syncClear = |(clr & lockstepBit_reg);

  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1) begin : gCh
      wire hit = doWrite && wInCh && wCh == c && wFull;
      wire cntWr = hit && wReg == `MTC_CH_CNT;
      // A preset to any lockstep channel presets them all.
      wire anyPreset = doWrite && wInCh && wFull &&
                       wReg == `MTC_CH_CNT && lockstepBit_reg[wCh];
      mtc_channel #(.FOUR((c == 0 || c == 3) ? 1 : 0)) uCh (
        .clk           (clk),
        .rst           (rst || standby_reg),
        .runBit        (runBit_reg[c]),
        .countTick     (countTick),
        .clearSource   (lockstepBit_reg[c] ? chCtrl_reg[c][2:0] :
                        (chCtrl_reg[c][2:0] == `MTC_CLR_SYNC ?
                         `MTC_CLR_NONE : chCtrl_reg[c][2:0])),
        .bufferAc      (chCtrl_reg[c][3]),
        .bufferBd      (chCtrl_reg[c][4]),
        .initLevel     (wData_reg[1:0]),
        .pinCtlWrite   (hit && wReg == `MTC_CH_PINCTL),
        .presetWrite   (cntWr || (anyPreset && lockstepBit_reg[c])),
        .presetValue   (wData_reg[15:0]),
        .syncClearIn   (syncClear && lockstepBit_reg[c]),
        .clearOut      (clr[c]),
        .grWrite       ({hit && wReg == `MTC_CH_GRD,
                         hit && wReg == `MTC_CH_GRC,
                         hit && wReg == `MTC_CH_GRB,
                         hit && wReg == `MTC_CH_GRA}),
        .grData        (wData_reg[15:0]),
        .timerCount_reg(cnt[c]),
        .grFlat_reg    (grs[c]),
        .overflowEvent (ovf[c]),
        .matchEvent    (mev[c]),
        .pinLevel_reg  (pin[c])
      );
      // Flags: hardware set wins over a zero written to clear.
      always @(posedge clk) begin
        if (rst) begin
          flag_reg[c] <= 5'h00;
        end else begin
          flag_reg[c] <= ((hit && wReg == `MTC_CH_CTRL) ?
                          (flag_reg[c] & wData_reg[12:8]) : flag_reg[c])
                         | {ovf[c], mev[c]};
        end
      end
      // Channel control and pin control registers.
      always @(posedge clk) begin
        if (rst) begin
          chCtrl_reg[c] <= 5'h00;
          pinCtl_reg[c] <= 2'h0;
        end else begin
          if (hit && wReg == `MTC_CH_CTRL) begin
            chCtrl_reg[c] <= ((c == 0 || c == 3) ? wData_reg[4:0] :
                              {2'b00, wData_reg[2:0]});
          end
          if (hit && wReg == `MTC_CH_PINCTL) begin
            pinCtl_reg[c] <= wData_reg[1:0];
          end
        end
      end
    end
  endgenerate

  // Write channel: take address and data in either order.
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MTC_RESP_OKAY;
      wAddrHeld_reg <= 1'b0;
      wDataHeld_reg <= 1'b0;
      wAddr_reg     <= 12'h000;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
    end else begin
      s_axi_awready <= !wAddrHeld_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wDataHeld_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        wAddr_reg     <= {s_axi_awaddr[11:2], 2'b00};
        wAddrHeld_reg <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wData_reg     <= s_axi_wdata;
        wStrb_reg     <= s_axi_wstrb;
        wDataHeld_reg <= 1'b1;
      end
      if (doWrite) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrErr ? `MTC_RESP_SLVERR : `MTC_RESP_OKAY;
        wAddrHeld_reg <= 1'b0;
        wDataHeld_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Unmapped addresses and partial counter writes answer with an error.
  always @* begin
    wrErr = 1'b1;
    if (wAddr_reg == `MTC_OFF_RUN || wAddr_reg == `MTC_OFF_SYNC ||
        wAddr_reg == `MTC_OFF_STANDBY) begin
      wrErr = 1'b0;
    end else if (wInCh) begin
      if (wReg == `MTC_CH_CTRL || wReg == `MTC_CH_PINCTL) begin
        wrErr = 1'b0;
      end else if (wReg == `MTC_CH_CNT || wReg == `MTC_CH_GRA ||
                   wReg == `MTC_CH_GRB) begin
        wrErr = !wFull;
      end else if ((wReg == `MTC_CH_GRC || wReg == `MTC_CH_GRD) &&
                   (wCh == 3'd0 || wCh == 3'd3)) begin
        wrErr = !wFull;
      end
    end
  end

  // Global registers; bits 7 and 6 are kept at zero.
  always @(posedge clk) begin
    if (rst) begin
      runBit_reg      <= 6'h00;
      lockstepBit_reg <= 6'h00;
      standby_reg     <= 1'b0;
    end else if (doWrite && wStrb_reg[0]) begin
      if (wAddr_reg == `MTC_OFF_RUN) begin
        runBit_reg <= wData_reg[5:0];
      end else if (wAddr_reg == `MTC_OFF_SYNC) begin
        lockstepBit_reg <= wData_reg[5:0];
      end else if (wAddr_reg == `MTC_OFF_STANDBY) begin
        standby_reg <= wData_reg[0];
      end
    end
  end

  // Read mux over the decoded address.
  always @* begin : pRd
    reg [11:0] rel;
    rel = 12'h000;
    rdValue = 32'h00000000;
    rdErr = 1'b1;
    rel = s_axi_araddr - `MTC_OFF_CH_BASE;
    if (s_axi_araddr[11:2] == `MTC_OFF_RUN >> 2) begin
      rdValue = {26'h0, runBit_reg};
      rdErr = 1'b0;
    end else if (s_axi_araddr[11:2] == `MTC_OFF_SYNC >> 2) begin
      rdValue = {26'h0, lockstepBit_reg};
      rdErr = 1'b0;
    end else if (s_axi_araddr[11:2] == `MTC_OFF_STANDBY >> 2) begin
      rdValue = {31'h0, standby_reg};
      rdErr = 1'b0;
    end else if (s_axi_araddr >= `MTC_OFF_CH_BASE && rel[11:9] == 3'd0 &&
                 rel[8:6] < 3'd6) begin
      rdErr = 1'b0;
      case ({rel[5:2], 2'b00})
        `MTC_CH_CTRL:   rdValue = {19'h0, flag_reg[rel[8:6]], 3'h0,
                                   chCtrl_reg[rel[8:6]]};
        `MTC_CH_PINCTL: rdValue = {30'h0, pinCtl_reg[rel[8:6]]};
        `MTC_CH_CNT:    rdValue = {16'h0, cnt[rel[8:6]]};
        `MTC_CH_GRA:    rdValue = {16'h0, grs[rel[8:6]][15:0]};
        `MTC_CH_GRB:    rdValue = {16'h0, grs[rel[8:6]][31:16]};
        // C and D exist only on the four-register channels.
        `MTC_CH_GRC:    begin
          rdErr   = rel[8:6] != 3'd0 && rel[8:6] != 3'd3;
          rdValue = rdErr ? 32'h00000000 : {16'h0, grs[rel[8:6]][47:32]};
        end
        `MTC_CH_GRD:    begin
          rdErr   = rel[8:6] != 3'd0 && rel[8:6] != 3'd3;
          rdValue = rdErr ? 32'h00000000 : {16'h0, grs[rel[8:6]][63:48]};
        end
        default:        rdErr = 1'b1;
      endcase
    end
  end

  // Read channel: one cycle to take, one to answer.
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MTC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdValue;
        s_axi_rresp  <= rdErr ? `MTC_RESP_SLVERR : `MTC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pin outputs registered once more at the top.
  always @(posedge clk) begin
    if (rst) begin
      timerIoPin <= 6'h00;
    end else begin
      timerIoPin <= pin;
    end
  end
endmodule // mtc_timer_core
`default_nettype wire

// *** include/mtc_consts.vh ***
// Offsets, reset values and codes for the timer core.
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH
`define MTC_OFF_RUN      12'h000
`define MTC_OFF_SYNC     12'h004
`define MTC_OFF_FLAGS    12'h008
`define MTC_OFF_STANDBY  12'h00c
`define MTC_OFF_CH_BASE  12'h100
`define MTC_CH_STRIDE    12'h040
`define MTC_CH_CTRL      6'h00
`define MTC_CH_PINCTL    6'h04
`define MTC_CH_CNT       6'h08
`define MTC_CH_GRA       6'h10
`define MTC_CH_GRB       6'h14
`define MTC_CH_GRC       6'h18
`define MTC_CH_GRD       6'h1c
`define MTC_CNT_RST      16'h0000
`define MTC_GR_RST       16'hffff
`define MTC_CLR_NONE     3'h0
`define MTC_CLR_A        3'h1
`define MTC_CLR_B        3'h2
`define MTC_CLR_SYNC     3'h3
`define MTC_CLR_C        3'h5
`define MTC_CLR_D        3'h6
`define MTC_RESP_OKAY    2'h0
`define MTC_RESP_SLVERR  2'h2
`endif

// *** verilog/mtc_channel.v ***
// One timer channel: counter, compare registers, buffering and pin level.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.vh"
module mtc_channel #(
  parameter FOUR = 1
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst,
  // Channel control.
  input  wire        runBit,
  input  wire        countTick,
  input  wire [2:0]  clearSource,
  input  wire        bufferAc,
  input  wire        bufferBd,
  input  wire [1:0]  initLevel,
  input  wire        pinCtlWrite,
  // Synchronous preset and clear.
  input  wire        presetWrite,
  input  wire [15:0] presetValue,
  input  wire        syncClearIn,
  output wire        clearOut,
  // Compare register writes.
  input  wire [3:0]  grWrite,
  input  wire [15:0] grData,
  // State.
  output reg  [15:0] timerCount_reg,
  output reg  [63:0] grFlat_reg,
  output wire        overflowEvent,
  output wire [3:0]  matchEvent,
  output reg         pinLevel_reg
);
  // Compare match per register, only while counting.
  wire [3:0] match;
  // Counter clear from this channel's own source.
  reg        ownClear;
  // Any clear, own or synchronous.
  wire       anyClear;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gMatch
      // Registers C and D exist only on four-register channels.
      if (i < 2 || FOUR) begin : gLive
        assign match[i] = runBit && countTick &&
                          (timerCount_reg == grFlat_reg[16*i +: 16]);
      end else begin : gDead
        assign match[i] = 1'b0;
      end
    end
  endgenerate

  // Selected clear source; a buffer register never clears the counter.
  always @* begin
    case (clearSource)
      `MTC_CLR_A: ownClear = match[0];
      `MTC_CLR_B: ownClear = match[1];
      `MTC_CLR_C: ownClear = match[2] && !bufferAc;
      `MTC_CLR_D: ownClear = match[3] && !bufferBd;
      default:    ownClear = 1'b0;
    endcase
  end

  assign clearOut = ownClear;
  assign anyClear = ownClear ||
                    (clearSource == `MTC_CLR_SYNC && syncClearIn && runBit);
  assign overflowEvent = runBit && countTick && !anyClear &&
                         (timerCount_reg == 16'hffff);
  assign matchEvent = match;

  // Counter: write wins over counting, clear wins over increment.
  always @(posedge clk) begin
    if (rst) begin
      timerCount_reg <= `MTC_CNT_RST;
    end else if (presetWrite) begin
      timerCount_reg <= presetValue;
    end else if (anyClear) begin
      timerCount_reg <= `MTC_CNT_RST;
    end else if (runBit && countTick) begin
      // Up only; wraps through zero and keeps going.
      timerCount_reg <= timerCount_reg + 16'h0001;
    end
  end

  // Compare registers; a match on A or B reloads it from its buffer.
  generate
    for (i = 0; i < 4; i = i + 1) begin : gGr
      // Reload strobe; only A and B of four-register channels reload.
      wire reload = (i < 2) && FOUR && (i == 0 ? bufferAc : bufferBd) &&
                    match[i];
      // Each entry writes only its own slice, so no slice has two drivers.
      always @(posedge clk) begin
        if (rst) begin
          grFlat_reg[16*i +: 16] <= `MTC_GR_RST;
        end else if (grWrite[i] && (i < 2 || FOUR)) begin
          grFlat_reg[16*i +: 16] <= grData;
        end else if (reload) begin
          // The buffer sits two entries up: C feeds A, D feeds B.
          grFlat_reg[16*i +: 16] <= grFlat_reg[(16*i+32)%64 +: 16];
        end else if (i >= 2 && !FOUR) begin
          grFlat_reg[16*i +: 16] <= 16'h0000;
        end
      end
    end
  endgenerate

  // Pin level: set on match A, cleared on match B; held when stopped.
  always @(posedge clk) begin
    if (rst) begin
      pinLevel_reg <= 1'b0;
    end else if (pinCtlWrite && !runBit) begin
      pinLevel_reg <= initLevel[1] ? initLevel[0] : 1'b0;
    end else if (match[0]) begin
      pinLevel_reg <= 1'b1;
    end else if (match[1]) begin
      pinLevel_reg <= 1'b0;
    end
  end
endmodule // mtc_channel
`default_nettype wire

// *** test/mtc_timer_core_monitor.sv ***
// Port-level bus and reset checks for the six-channel timer core.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.vh"
module mtc_timer_core_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Write channels.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Compare output levels.
  input wire logic [5:0]  timerIoPin
);
  // Everything here lives in the one system clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Both halves of a write taken at the same edge.
  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A read address taken.
  sequence sRdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // The response must follow a taken write within two cycles.
  a_write_answer: assert property (sWrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (sRdTaken |=> s_axi_rvalid)
    else $error("read data late");
  // An answer stands, unchanged, until the master takes it.
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  // Ready strobes are single-cycle pulses.
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  a_arready_pulse: assert property ($rose(s_axi_arready) |=> $fell(s_axi_arready))
    else $error("arready held");
  // Every register is sixteen bits wide or narrower.
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // A refused read returns no data.
  a_err_no_data: assert property (s_axi_rvalid
    && s_axi_rresp == `MTC_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
    else $error("refused read has data");
  // Leaving reset, no answer is pending and all pins are low.
  a_reset_quiet: assert property ($fell(rst) |-> !s_axi_bvalid
    && !s_axi_rvalid && timerIoPin == 6'h00)
    else $error("outputs not cleared by reset");
endmodule // mtc_timer_core_monitor
bind mtc_timer_core mtc_timer_core_monitor i_mon (.clk(clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timerIoPin(timerIoPin));
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the six-channel timer core.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
  typedef struct {
    logic [11:0] a; logic [31:0] d; logic [3:0] s;
    logic [1:0] br; logic [31:0] rd; logic [1:0] rr;
  } mtc_row_t;
  localparam logic [1:0] OK = `MTC_RESP_OKAY;
  localparam logic [1:0] ER = `MTC_RESP_SLVERR;
  logic        clk = 1'b0, rst = 1'b1, countTick = 1'b1;
  logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
  logic [31:0] wData = 32'h0, rData, d, v;
  logic [3:0]  wStrb = 4'h0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, r;
  logic [5:0]  timerIoPin;
  logic        ok;
  int          error_cnt = 0, n_compared = 0;
  int          k;         // Bounded wait counter of the hand-written tests.
  mtc_row_t    rows[$];   // Plain register accesses and their answers.
  always #5 clk = ~clk;   // 100 MHz system clock.
  mtc_timer_core i_mtc_timer_core (.clk(clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .countTick(countTick),
    .timerIoPin(timerIoPin));
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A bus that never answers counts as a mismatch and ends the run.
  task automatic hang(input int n);
    if (n == 100) begin
      error_cnt++;
      $display("wrong value at %0t: bus gave no answer", $time);
      stop_test();
    end
  endtask
  // Byte address of a channel register.
  function automatic logic [11:0] chA(input int c, input int o);
    return 12'(`MTC_OFF_CH_BASE + `MTC_CH_STRIDE * c + o);
  endfunction
  // One write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] x,
                    input logic [3:0] s, output logic [1:0] q);
    int n;
    @(posedge clk);
    awAddr <= a; wData <= x; wStrb <= s;
    awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    q = bResp;
    bReady <= 1'b0;
    hang(n);
  endtask
  // One read; data and response are taken at the edge that shows rvalid.
  task automatic rd(input logic [11:0] a, output logic [31:0] x,
                    output logic [1:0] q);
    int n;
    @(posedge clk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    x = rData;
    q = rResp;
    rReady <= 1'b0;
    hang(n);
  endtask
  // Full-word write that must be accepted.
  task automatic w16(input logic [11:0] a, input logic [31:0] x);
    logic [1:0] q;
    wr(a, x, 4'hf, q);
    `CHK(q, OK)
  endtask
  // Read that must be accepted and return the given value.
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, OK)
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  initial begin
    // Counters and every compare slot; missing slots must be refused.
    for (int c = 0; c < 6; c++) begin
      rows.push_back('{chA(c, `MTC_CH_CNT), 32'h1000 + c, 4'hf, OK,
                       32'h1000 + c, OK});
      for (int g = 0; g < 4; g++) begin
        ok = (c == 0 || c == 3 || g < 2);
        rows.push_back('{chA(c, 'h10 + 4 * g), 32'h2000 + 16 * c + g, 4'hf,
          ok ? OK : ER, ok ? 32'h2000 + 16 * c + g : 32'h0, ok ? OK : ER});
      end
    end
    // Byte-wide counter and compare writes must leave the value alone; a write to the flags offset is refused.
    rows.push_back('{chA(1, `MTC_CH_CNT), 32'h5555, 4'h1, ER, 32'h1001, OK});
    rows.push_back('{chA(0, `MTC_CH_GRA), 32'h7777, 4'h2, ER, 32'h2000, OK});
    rows.push_back('{`MTC_OFF_FLAGS, 32'h1, 4'hf, ER, 32'h0, ER});
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk(`MTC_OFF_RUN, 32'h0);
    chk(`MTC_OFF_SYNC, 32'h0);
    for (int c = 0; c < 6; c++) chk(chA(c, `MTC_CH_CNT), 32'h0);
    done("reset values");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].s, r);
      `CHK(r, rows[i].br)
      rd(rows[i].a, d, r);
      `CHK(d, rows[i].rd)
      `CHK(r, rows[i].rr)
    end
    done("register table");
    // Free running: counts up while run, holds once stopped.
    w16(chA(1, `MTC_CH_CNT), 32'h10);
    w16(`MTC_OFF_RUN, 32'h02);
    repeat (20) @(posedge clk);
    w16(`MTC_OFF_RUN, 32'h00);
    chk(`MTC_OFF_RUN, 32'h0);
    rd(chA(1, `MTC_CH_CNT), v, r);
    `CHK(v > 32'h10 && v < 32'h60, 1'b1)
    repeat (10) @(posedge clk);
    chk(chA(1, `MTC_CH_CNT), v);
    done("free running");
    // Overflow wraps to zero and raises the flag.
    w16(chA(2, `MTC_CH_CNT), 32'hfffe);
    w16(`MTC_OFF_RUN, 32'h04);
    repeat (8) @(posedge clk);
    w16(`MTC_OFF_RUN, 32'h00);
    rd(chA(2, `MTC_CH_CNT), v, r);
    `CHK(v < 32'h40, 1'b1)
    rd(chA(2, `MTC_CH_CTRL), d, r);
    `CHK(d[12], 1'b1)
    done("overflow");
    // Period on compare A with C as its buffer; A match drives the pin high.
    w16(chA(0, `MTC_CH_GRA), 32'h5);
    w16(chA(0, `MTC_CH_GRC), 32'h8);
    w16(chA(0, `MTC_CH_CNT), 32'h0);
    w16(chA(0, `MTC_CH_CTRL), 32'h9);
    w16(`MTC_OFF_RUN, 32'h01);
    repeat (60) @(posedge clk);
    w16(`MTC_OFF_RUN, 32'h00);
    chk(chA(0, `MTC_CH_GRA), 32'h8);
    rd(chA(0, `MTC_CH_CNT), v, r);
    `CHK(v <= 32'h8, 1'b1)
    rd(chA(0, `MTC_CH_CTRL), d, r);
    `CHK(d[8], 1'b1)
    `CHK(timerIoPin[0], 1'b1)
    w16(chA(0, `MTC_CH_PINCTL), 32'h2);
    repeat (3) @(posedge clk);
    `CHK(timerIoPin[0], 1'b0)
    w16(chA(0, `MTC_CH_PINCTL), 32'h3);
    repeat (3) @(posedge clk);
    `CHK(timerIoPin[0], 1'b1)
    done("periodic and buffer");
    // Channels 1 and 3 locked together; channel 5 stays independent.
    w16(`MTC_OFF_SYNC, 32'h0a);
    w16(chA(1, `MTC_CH_CNT), 32'h0);
    chk(chA(3, `MTC_CH_CNT), 32'h0);
    chk(chA(5, `MTC_CH_CNT), 32'h1005);
    w16(chA(1, `MTC_CH_GRA), 32'h30);
    w16(chA(1, `MTC_CH_CTRL), 32'h1);
    w16(chA(3, `MTC_CH_CTRL), 32'h3);
    w16(`MTC_OFF_RUN, 32'h0a);
    repeat (100) @(posedge clk);
    w16(`MTC_OFF_RUN, 32'h00);
    rd(chA(1, `MTC_CH_CNT), v, r);
    `CHK(v <= 32'h30, 1'b1)
    chk(chA(3, `MTC_CH_CNT), v);
    done("synchronous");
    // Standby forces the counters back to zero.
    w16(`MTC_OFF_STANDBY, 32'h1);
    chk(chA(5, `MTC_CH_CNT), 32'h0);
    w16(`MTC_OFF_STANDBY, 32'h0);
    done("standby");
    // Answer held back: rvalid and its data must stand until rready.
    @(posedge clk);
    arAddr <= `MTC_OFF_SYNC;
    arValid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arReady) break;
    end
    arValid <= 1'b0;
    repeat (4) @(posedge clk);
    rReady <= 1'b1;
    @(posedge clk);
    rReady <= 1'b0;
    `CHK(rValid, 1'b1)
    `CHK(rData, 32'h0000000a)
    hang(k);
    done("held answer");
    stop_test();
  end
endmodule // tb
`default_nettype wire
